// file: hdl/drac_controller.v
/*
  Dynamic RAM controller core: arbitration of read, write and refresh,
  refresh interval timer, refresh row counter, address multiplexer and
  strobe sequencing for two banks.
  Assumes requests are asynchronous to i_core_clk; the core clock is the
  oscillator output selected by the clock strap outside this module.
*/
`timescale 1ns/1ps
`include "drac_consts.vh"

module drac_controller
(
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_read_reqn,
  input wire i_write_reqn,
  input wire i_protected_selectn,
  input wire i_ext_refresh_req,
  input wire i_adv_read_mode,
  input wire i_addr_latch_en,
  input wire i_read_status_line,
  input wire i_bank_select,
  input wire [`DRAC_ADDR_W-1:0] i_row_addr_in,
  input wire [`DRAC_ADDR_W-1:0] i_col_addr_in,
  output reg [`DRAC_ADDR_W-1:0] o_dram_addrn,
  output reg o_ras0n,
  output reg o_ras1n,
  output reg o_casn,
  output reg o_wen,
  output reg o_early_access_ackn,
  output reg o_transfer_done_ackn
);

  // ========================================================================
  // State codes
  // ========================================================================
  localparam ST_IDLE = 3'h0;
  localparam ST_ROW = 3'h1;
  localparam ST_COLA = 3'h2;
  localparam ST_CAS = 3'h3;
  localparam ST_TRANSFER_DONE_ACK = 3'h4;
  localparam ST_REF = 3'h5;
  localparam ST_PRE = 3'h6;

  // ========================================================================
  // Synchronisers
  // ========================================================================
  reg [1:0] rd_sync_reg;
  reg [1:0] wr_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] ale_sync_reg;
  reg [1:0] st_sync_reg;
  reg [1:0] eref_sync_reg;
  reg eref_latch_reg;
  reg ale_prev_reg;
  reg adv_rd_pend_reg;
  reg [2:0] state_reg;
  reg [`DRAC_SEQ_W-1:0] seq_reg;
  reg [`DRAC_TMR_W-1:0] tmr_reg;
  reg [`DRAC_ROWCNT_W-1:0] rowcnt_reg;
  reg iref_pend_reg;
  reg dly_ack_reg;
  reg is_write_reg;
  reg bank_reg;
  reg ref_done;
  reg ref_cyc_reg;

  wire rd_req;
  wire wr_req;
  wire selected;
  wire ale_fall;
  wire mem_req;
  wire ref_req;
  wire eref_pin;

  // Advanced-read strap blocks external refresh
  assign eref_pin = eref_sync_reg[1] & ~i_adv_read_mode;

  // Two flops for each request; the refresh latch adds a third for external refresh
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_sync_reg <= 2'h0;
      wr_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h0;
      ale_sync_reg <= 2'h0;
      st_sync_reg <= 2'h0;
      eref_sync_reg <= 2'h0;
      ale_prev_reg <= 1'b0;
    end
    else
    begin
      rd_sync_reg <= {rd_sync_reg[0], ~i_read_reqn};
      wr_sync_reg <= {wr_sync_reg[0], ~i_write_reqn};
      cs_sync_reg <= {cs_sync_reg[0], ~i_protected_selectn};
      ale_sync_reg <= {ale_sync_reg[0], i_addr_latch_en};
      st_sync_reg <= {st_sync_reg[0], i_read_status_line};
      eref_sync_reg <= {eref_sync_reg[0], i_ext_refresh_req};
      ale_prev_reg <= ale_sync_reg[1];
    end
  end

  // Latch enable falling edge starts an advanced read
  assign ale_fall = ale_prev_reg & ~ale_sync_reg[1];

  // Read source depends on read mode strap
  assign rd_req = i_adv_read_mode ? adv_rd_pend_reg : rd_sync_reg[1];
  assign wr_req = wr_sync_reg[1];
  assign selected = cs_sync_reg[1];
  assign mem_req = selected & (rd_req | wr_req);
  assign ref_req = iref_pend_reg | eref_latch_reg;

  // ========================================================================
  // External refresh latch and advanced read pending flag
  // ========================================================================
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      eref_latch_reg <= 1'b0;
      adv_rd_pend_reg <= 1'b0;
    end
    else
    begin
      // Held request wins over the clear, so the latch stays set
      if (eref_pin)
        eref_latch_reg <= 1'b1;
      else if (ref_done)
        eref_latch_reg <= 1'b0;
      // Latch pulse ignored while status is low
      if (ale_fall & st_sync_reg[1])
        adv_rd_pend_reg <= 1'b1;
      else if (state_reg == ST_TRANSFER_DONE_ACK && !is_write_reg)
        adv_rd_pend_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Refresh interval timer and row counter
  // ========================================================================
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tmr_reg <= {`DRAC_TMR_W{1'b0}};
      iref_pend_reg <= 1'b0;
      rowcnt_reg <= {`DRAC_ROWCNT_W{1'b0}};
    end
    else
    begin
      if (ref_done)
      begin
        tmr_reg <= {`DRAC_TMR_W{1'b0}};
        iref_pend_reg <= 1'b0;
        rowcnt_reg <= rowcnt_reg + 8'h01;
      end
      else if (eref_latch_reg)
        tmr_reg <= {`DRAC_TMR_W{1'b0}};
      else if (tmr_reg == `DRAC_TMR_TC)
        iref_pend_reg <= 1'b1;
      else
        tmr_reg <= tmr_reg + 10'h001;
    end
  end

  // ========================================================================
  // Arbiter and cycle sequencer
  // ========================================================================
  always @*
  begin
    ref_done = (state_reg == ST_REF) && (seq_reg == `DRAC_T_REF_RAS);
  end

  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= ST_IDLE;
      seq_reg <= {`DRAC_SEQ_W{1'b0}};
      dly_ack_reg <= 1'b0;
      is_write_reg <= 1'b0;
      bank_reg <= 1'b0;
      ref_cyc_reg <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_reg + 3'h1;
      // Request seen while refreshing delays the early ack
      if ((state_reg == ST_REF || (state_reg == ST_PRE && ref_cyc_reg)) && mem_req)
        dly_ack_reg <= 1'b1;
      case (state_reg)
        ST_IDLE:
        begin
          seq_reg <= {`DRAC_SEQ_W{1'b0}};
          // After a refresh a waiting access goes first, so refresh cannot lock it out
          if (ref_req && !(mem_req && ref_cyc_reg))
          begin
            state_reg <= ST_REF;
            ref_cyc_reg <= 1'b1;
          end
          else if (mem_req)
          begin
            state_reg <= ST_ROW;
            ref_cyc_reg <= 1'b0;
            is_write_reg <= wr_req;
            bank_reg <= i_bank_select;
          end
        end
        ST_ROW:
          if (seq_reg == `DRAC_T_RAS_TO_COL)
          begin
            state_reg <= ST_COLA;
            seq_reg <= {`DRAC_SEQ_W{1'b0}};
          end
        ST_COLA:
          if (seq_reg == `DRAC_T_COL_TO_CAS)
          begin
            state_reg <= ST_CAS;
            seq_reg <= {`DRAC_SEQ_W{1'b0}};
          end
        ST_CAS:
          if (seq_reg == `DRAC_T_CAS_TO_TRANSFER_DONE_ACK)
          begin
            state_reg <= ST_TRANSFER_DONE_ACK;
            seq_reg <= {`DRAC_SEQ_W{1'b0}};
          end
        ST_TRANSFER_DONE_ACK:
        begin
          state_reg <= ST_PRE;
          seq_reg <= {`DRAC_SEQ_W{1'b0}};
          if (!is_write_reg)
            dly_ack_reg <= 1'b0;
        end
        ST_REF:
          if (ref_done)
          begin
            state_reg <= ST_PRE;
            seq_reg <= {`DRAC_SEQ_W{1'b0}};
          end
        ST_PRE:
          if (seq_reg == `DRAC_T_PRECHARGE)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Registered DRAM strobes, address and acknowledges
  // ========================================================================
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_dram_addrn <= {`DRAC_ADDR_W{1'b1}};
      o_ras0n <= 1'b1;
      o_ras1n <= 1'b1;
      o_casn <= 1'b1;
      o_wen <= 1'b1;
      o_early_access_ackn <= 1'b1;
      o_transfer_done_ackn <= 1'b1;
    end
    else
    begin
      // Inverted address source selection
      if (state_reg == ST_REF)
        o_dram_addrn <= ~rowcnt_reg;
      else if (state_reg == ST_COLA || state_reg == ST_CAS || state_reg == ST_TRANSFER_DONE_ACK)
        o_dram_addrn <= ~{1'b0, i_col_addr_in[`DRAC_ADDR_LOW_W-1:0]};
      else
        o_dram_addrn <= ~{1'b0, i_row_addr_in[`DRAC_ADDR_LOW_W-1:0]};
      // Refresh fires both banks; access fires the selected one
      o_ras0n <= ~((state_reg == ST_REF) ||
        ((state_reg >= ST_ROW && state_reg <= ST_TRANSFER_DONE_ACK) && !bank_reg));
      o_ras1n <= ~((state_reg == ST_REF) ||
        ((state_reg >= ST_ROW && state_reg <= ST_TRANSFER_DONE_ACK) && bank_reg));
      o_casn <= ~(state_reg == ST_CAS || state_reg == ST_TRANSFER_DONE_ACK);
      // Write strobe leads column strobe by two clocks
      o_wen <= ~(is_write_reg && (state_reg == ST_COLA || state_reg == ST_CAS ||
        state_reg == ST_TRANSFER_DONE_ACK));
      o_transfer_done_ackn <= ~(state_reg == ST_TRANSFER_DONE_ACK);
      // Early ack at row strobe, or with transfer ack when delayed
      if (state_reg == ST_ROW && seq_reg == 3'h0)
        o_early_access_ackn <= dly_ack_reg;
      else if (state_reg == ST_TRANSFER_DONE_ACK)
        o_early_access_ackn <= 1'b0;
      else if (state_reg == ST_PRE || state_reg == ST_IDLE || state_reg == ST_REF)
        o_early_access_ackn <= 1'b1;
    end
  end

endmodule // drac_controller

// file: hdl/drac_consts.vh
/*
  Constants for the dynamic RAM refresh arbiter controller: timing counts
  and address widths.
  Assumes a 40 MHz core clock (25 ns period).
*/
`ifndef DRAC_CONSTS_VH
`define DRAC_CONSTS_VH

// ==========================================================================
// Clock and refresh timing
// ==========================================================================
`define DRAC_CLK_PERIOD_PS 25000
`define DRAC_REF_INTERVAL_NS 12800
`define DRAC_REF_CYCLES ((`DRAC_REF_INTERVAL_NS * 1000) / `DRAC_CLK_PERIOD_PS)
`define DRAC_TMR_W 10
`define DRAC_TMR_TC 10'h1FF

// ==========================================================================
// Cycle sequencing (counts in core clocks)
// ==========================================================================
`define DRAC_T_RAS_TO_COL 3'h1
`define DRAC_T_COL_TO_CAS 3'h1
`define DRAC_T_CAS_TO_TRANSFER_DONE_ACK 3'h2
`define DRAC_T_REF_RAS 3'h4
`define DRAC_T_PRECHARGE 3'h2
`define DRAC_SEQ_W 3

// ==========================================================================
// Widths
// ==========================================================================
`define DRAC_ADDR_W 8
`define DRAC_ROWCNT_W 8
`define DRAC_ADDR_LOW_W 7

`endif

// file: verification/drac_ctrl_asserts.sv
/* Port checker for the controller core.
   Assumes one core clock and an async active-low reset. */
`timescale 1ns/1ps
`include "drac_consts.vh"
module drac_ctrl_asserts
(
  input wire i_core_clk,
  input wire i_rstn,
  input wire [`DRAC_ADDR_W-1:0] o_dram_addrn,
  input wire o_ras0n,
  input wire o_ras1n,
  input wire o_casn,
  input wire o_wen,
  input wire o_early_access_ackn,
  input wire o_transfer_done_ackn
);
  // ==========
  // Helpers
  wire refr = !o_ras0n && !o_ras1n;
  reg [9:0] gap_reg;
  // Cycles since the last refresh
  always @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
      gap_reg <= 10'h000;
    else if (refr)
      gap_reg <= 10'h000;
    else if (gap_reg != 10'h3FF)
      gap_reg <= gap_reg + 10'h001;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========
  // Properties
  sequence s_transfer_done_ack;
    $fell(o_transfer_done_ackn) ##1 o_transfer_done_ackn;
  endsequence
  property p_ref_quiet; refr |-> o_casn && o_wen && o_early_access_ackn && o_transfer_done_ackn; endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("strobe in refresh");
  property p_transfer_done_ack_one; $fell(o_transfer_done_ackn) |=> o_transfer_done_ackn; endproperty
  a_transfer_done_ack_one: assert property (p_transfer_done_ack_one) else $error("long transfer_done_ack");
  property p_transfer_done_ack_cas; !o_transfer_done_ackn |-> !o_casn && (o_ras0n != o_ras1n); endproperty
  a_transfer_done_ack_cas: assert property (p_transfer_done_ack_cas) else $error("transfer_done_ack outside access");
  property p_cas_row; $fell(o_casn) |-> (o_ras0n != o_ras1n) && ($past(o_ras0n, 2) != $past(o_ras1n, 2)); endproperty
  a_cas_row: assert property (p_cas_row) else $error("cas before row");
  property p_col_addr; !o_casn |-> o_dram_addrn[7]; endproperty
  a_col_addr: assert property (p_col_addr) else $error("column bit 7");
  property p_we_early; $fell(o_wen) |-> o_casn; endproperty
  a_we_early: assert property (p_we_early) else $error("late write strobe");
  property p_ack_transfer_done_ack; !o_transfer_done_ackn |-> !o_early_access_ackn; endproperty
  a_ack_transfer_done_ack: assert property (p_ack_transfer_done_ack) else $error("no ack at transfer_done_ack");
  property p_timer; gap_reg < 10'h280; endproperty
  a_timer: assert property (p_timer) else $error("refresh overdue");
  property p_release; s_transfer_done_ack |-> ##[0:5] (o_ras0n && o_ras1n && o_early_access_ackn); endproperty
  a_release: assert property (p_release) else $error("cycle not ended");
  property p_idle; refr && !$past(refr) |-> $past(o_ras0n) && $past(o_ras1n); endproperty
  a_idle: assert property (p_idle) else $error("refresh not idle");
endmodule // drac_ctrl_asserts
bind drac_controller drac_ctrl_asserts u_chk (.i_core_clk, .i_rstn, .o_dram_addrn, .o_ras0n, .o_ras1n,
  .o_casn, .o_wen, .o_early_access_ackn, .o_transfer_done_ackn);

// file: verification/drac_dram_model.sv
/* Behavioural DRAM array: latches row and column addresses, logs refreshes.
   Assumes strobes change only on the rising clock edge. */
`timescale 1ns/1ps
module drac_dram_model
(
  input wire i_clk,
  input wire i_ras0n,
  input wire i_ras1n,
  input wire i_casn,
  input wire [7:0] i_addrn,
  output reg [7:0] o_row = 8'h00,
  output reg [7:0] o_col = 8'h00,
  output reg [7:0] o_ref = 8'h00,
  output reg [7:0] o_cnt = 8'h00,
  output reg o_bank = 1'b0
);
  // ==========
  // Strobe history
  reg ras0_reg = 1'b1;
  reg ras1_reg = 1'b1;
  reg cas_reg = 1'b1;
  // Capture the address on each strobe fall
  always @(posedge i_clk)
  begin
    ras0_reg <= i_ras0n;
    ras1_reg <= i_ras1n;
    cas_reg <= i_casn;
    if (!i_ras0n && !i_ras1n && (ras0_reg || ras1_reg))
    begin
      o_ref <= i_addrn;
      o_cnt <= o_cnt + 8'h01;
    end
    else if ((i_ras0n ^ i_ras1n) && ras0_reg && ras1_reg)
    begin
      o_row <= i_addrn;
      o_bank <= i_ras0n;
    end
    if (!i_casn && cas_reg)
      o_col <= i_addrn;
  end
endmodule // drac_dram_model

// file: verification/dram_refresh_arbiter_controller_tb.sv
/* Self-checking bench for the controller core.
   Assumes the checker and the DRAM model are compiled first. */
`timescale 1ns/1ps
module dram_refresh_arbiter_controller_tb;
  logic clk = 1'b0, rstn = 1'b0, rdn = 1'b1, wrn = 1'b1, seln = 1'b1, erq = 1'b0, bank = 1'b0;
  logic adv = 1'b0, ale = 1'b0, stat = 1'b0;
  logic [7:0] row = 8'h00, col = 8'h00, a0, c0;
  wire [7:0] addrn, m_row, m_col, m_ref, m_cnt;
  wire ras0n, ras1n, casn, wen, ackn, xackn, m_bank;
  int mismatches = 0, comparisons = 0, n, i;
  logic early, wlow;
  // Rows: drop select, write, bank, row, column
  logic [18:0] rows [4] = '{19'h01234, 19'h3FF80, 19'h2007F, 19'h555AA};
  drac_controller dut (.i_core_clk(clk), .i_rstn(rstn), .i_read_reqn(rdn), .i_write_reqn(wrn),
    .i_protected_selectn(seln), .i_ext_refresh_req(erq), .i_adv_read_mode(adv), .i_addr_latch_en(ale),
    .i_read_status_line(stat), .i_bank_select(bank), .i_row_addr_in(row), .i_col_addr_in(col),
    .o_dram_addrn(addrn), .o_ras0n(ras0n), .o_ras1n(ras1n), .o_casn(casn), .o_wen(wen),
    .o_early_access_ackn(ackn), .o_transfer_done_ackn(xackn));
  drac_dram_model mdl (.i_clk(clk), .i_ras0n(ras0n), .i_ras1n(ras1n), .i_casn(casn), .i_addrn(addrn),
    .o_row(m_row), .o_col(m_col), .o_ref(m_ref), .o_cnt(m_cnt), .o_bank(m_bank));
  // ==========
  // Tasks
  task check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wait_ref;
    c0 = m_cnt;
    for (n = 0; m_cnt === c0 && n < 1000; n++) @(posedge clk);
  endtask
  task ext_ref;
    erq <= 1'b1;
    repeat (2) @(posedge clk);
    erq <= 1'b0;
    wait_ref;
  endtask
  // Access issued at an edge, held until the transfer ack
  task access(input logic [18:0] t);
    bank <= t[16];
    row <= t[15:8];
    col <= t[7:0];
    seln <= 1'b0;
    if (t[17]) wrn <= 1'b0; else rdn <= 1'b0;
    early = 1'b0;
    wlow = 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      if (t[18] && (ras0n === 1'b0 || ras1n === 1'b0)) seln <= 1'b1;
      if (ackn === 1'b0 && xackn === 1'b1) early = 1'b1;
      if (wen === 1'b0) wlow = 1'b1;
      n++;
    end while (xackn !== 1'b0 && n < 100);
    check(n < 100, 1'b1);
    rdn <= 1'b1;
    wrn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // ==========
  // Clock, watchdog and sequence
  initial forever #12.5 clk = ~clk;
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({ras0n, ras1n, casn, wen, ackn, xackn}, 8'h3F);
    check(addrn, 8'hFF);
    for (i = 0; i < 4; i++)
    begin
      access(rows[i]);
      check(m_row, ~{1'b0, rows[i][14:8]});
      check(m_col, ~{1'b0, rows[i][6:0]});
      check(m_bank, rows[i][16]);
      check(early, 1'b1);
      check(wlow, rows[i][17]);
    end
    seln <= 1'b1;
    rdn <= 1'b0;
    for (n = 0; (ras0n ^ ras1n) !== 1'b1 && n < 40; n++) @(posedge clk);
    check(n, 8'd40);
    rdn <= 1'b1;
    ext_ref;
    a0 = m_ref;
    check(n < 1000, 1'b1);
    ext_ref;
    check(m_ref, a0 - 8'h01);
    wait_ref;
    check(n >= 400 && n <= 640, 1'b1);
    repeat (12) @(posedge clk);
    seln <= 1'b0;
    rdn <= 1'b0;
    erq <= 1'b1;
    for (n = 0; ras0n === 1'b1 && ras1n === 1'b1 && n < 100; n++) @(posedge clk);
    check(ras0n ^ ras1n, 1'b1);
    for (n = 0; xackn !== 1'b0 && n < 100; n++) @(posedge clk);
    wait_ref;
    check(n < 10, 1'b1);
    for (n = 0; !(ras0n === 1'b1 && ras1n === 1'b1) && n < 100; n++) @(posedge clk);
    for (n = 0; ras0n === 1'b1 && ras1n === 1'b1 && n < 100; n++) @(posedge clk);
    check(ras0n ^ ras1n, 1'b1);
    erq <= 1'b0;
    for (n = 0; xackn !== 1'b0 && n < 100; n++) @(posedge clk);
    rdn <= 1'b1;
    repeat (30) @(posedge clk);
    ext_ref;
    access(19'h01234);
    check(early, 1'b0);
    access(19'h01234);
    check(early, 1'b1);
    // Advanced read strap: refresh pin and low-status latch pulse are ignored
    adv <= 1'b1;
    erq <= 1'b1;
    ale <= 1'b1;
    repeat (2) @(posedge clk);
    ale <= 1'b0;
    for (n = 0; ras0n === 1'b1 && ras1n === 1'b1 && n < 20; n++) @(posedge clk);
    check(n, 8'd20);
    stat <= 1'b1;
    ale <= 1'b1;
    repeat (2) @(posedge clk);
    ale <= 1'b0;
    for (n = 0; xackn !== 1'b0 && n < 40; n++) @(posedge clk);
    check(n < 40, 1'b1);
    check(m_row, ~{1'b0, 7'h12});
    check(m_col, ~{1'b0, 7'h34});
    final_report;
  end
endmodule // dram_refresh_arbiter_controller_tb
